// >>> bench/capture_channel_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module capture_channel_monitor (
    input wire logic        I_CLOCK,
    input wire logic        I_RST,
    input wire logic        I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0]  I_HTRANS,
    input wire logic        I_HWRITE,
    input wire logic [2:0]  I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic        I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic        O_HREADYOUT,
    input wire logic        O_HRESP,
    input wire logic        I_CAPTURE_INPUT_PIN,
    input wire logic [15:0] I_SECOND_TIMER_COUNT,
    input wire logic [15:0] I_THIRD_TIMER_COUNT,
    input wire logic        I_CPU_IDLE,
    input wire logic        I_CPU_SLEEP,
    input wire logic        O_IRQ
);
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [2:0]  mode_r;
    logic [2:0]  en_r;
    logic        take;
    logic        rd_ctrl;
    logic        off;

    // ----------------------------------------
    // Shadow of written registers
    // ----------------------------------------
    assign take = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign rd_ctrl = take && !I_HWRITE && I_HADDR[7:0] == 8'h00;
    assign off = mode_r == 3'h0 || mode_r == 3'h6 || mode_r == 3'h7;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            mode_r    <= 3'h0;
            en_r      <= 3'h0;
        end else if (I_HREADY) begin
            wr_pend_r <= take && I_HWRITE;
            wr_addr_r <= I_HADDR[7:0];
            if (wr_pend_r && wr_addr_r == 8'h00) mode_r <= I_HWDATA[2:0];
            if (wr_pend_r && wr_addr_r == 8'h10) en_r <= I_HWDATA[2:0];
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    hresp_okay_a: assert property (O_HRESP == 1'b0) else $error("error response seen");
    zero_wait_a: assert property (O_HREADYOUT == 1'b1) else $error("wait state seen");
    ctrl_unused_zero_a: assert property (rd_ctrl |=> O_HRDATA[31:14] == 18'h0 && O_HRDATA[12:8] == 5'h0)
        else $error("unused control bits not zero");
    stat_width_a: assert property (take && !I_HWRITE && I_HADDR[7:0] == 8'h08 |=> O_HRDATA[31:3] == 29'h0)
        else $error("status upper bits not zero");
    unmapped_zero_a: assert property (take && !I_HWRITE && I_HADDR[7:0] == 8'h20 |=> O_HRDATA == 32'h0)
        else $error("unmapped read not zero");
    reset_quiet_a: assert property (disable iff (1'b0) I_RST |=> !O_IRQ && O_HRDATA == 32'h0)
        else $error("outputs not cleared by reset");
    irq_masked_a: assert property (en_r == 3'h0 && $past(en_r) == 3'h0 |-> !O_IRQ)
        else $error("interrupt with all sources disabled");
    mode_off_empty_a: assert property (rd_ctrl && off && $past(off) && $past(off, 2) |=> O_HRDATA[4:3] == 2'b00)
        else $error("status flags set while channel off");

    irq_seen_c: cover property ($rose(O_IRQ));
    buf_read_c: cover property (take && !I_HWRITE && I_HADDR[7:0] == 8'h04);
    ctrl_write_c: cover property (take && I_HWRITE && I_HADDR[7:0] == 8'h00);
endmodule

bind input_capture_channel capture_channel_monitor u_mon (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
    .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .I_CAPTURE_INPUT_PIN(I_CAPTURE_INPUT_PIN), .I_SECOND_TIMER_COUNT(I_SECOND_TIMER_COUNT),
    .I_THIRD_TIMER_COUNT(I_THIRD_TIMER_COUNT), .I_CPU_IDLE(I_CPU_IDLE), .I_CPU_SLEEP(I_CPU_SLEEP),
    .O_IRQ(O_IRQ));

`default_nettype wire

// >>> bench/capture_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module capture_pin_model (
    input  wire logic i_clock,
    output logic      o_pin
);
    initial o_pin = 1'b0;

    // Three cycles per level, above the two the synchroniser needs
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge i_clock);
            o_pin <= 1'b1;
            repeat (3) @(posedge i_clock);
            o_pin <= 1'b0;
            repeat (3) @(posedge i_clock);
        end
    endtask
endmodule

`default_nettype wire

// >>> bench/input_capture_channel_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "capture_map.svh"

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t ns: got %h want %h", $time, g, e); end end

module input_capture_channel_tb_top;
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] cpi;
        logic       tb;
        logic [4:0] n;
        logic [2:0] caps;
        logic [2:0] stat;
    } row_t;

    logic        clk, rst, hsel, hwrite, hready, hresp, pin, idle, sleep, irq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] sec;
    int          n_mismatch = 0;
    int          total_checks = 0;

    // Mode, per-interrupt count, time base, pulses, captures, status
    row_t rows [9] = '{
        '{3'h0, 2'h0, 1'b1, 5'd3, 3'd0, 3'h0}, '{3'h1, 2'h3, 1'b1, 5'd2, 3'd4, 3'h1},
        '{3'h2, 2'h1, 1'b1, 5'd1, 3'd1, 3'h0}, '{3'h3, 2'h2, 1'b0, 5'd3, 3'd3, 3'h1},
        '{3'h4, 2'h0, 1'b1, 5'd7, 3'd1, 3'h1}, '{3'h5, 2'h0, 1'b0, 5'd16, 3'd1, 3'h1},
        '{3'h6, 2'h0, 1'b1, 5'd2, 3'd0, 3'h0}, '{3'h3, 2'h3, 1'b0, 5'd5, 3'd4, 3'h5},
        '{3'h7, 2'h0, 1'b1, 5'd2, 3'd0, 3'h0}};

    input_capture_channel uut (
        .I_CLOCK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_CAPTURE_INPUT_PIN(pin),
        .I_SECOND_TIMER_COUNT(sec), .I_THIRD_TIMER_COUNT(~sec), .I_CPU_IDLE(idle),
        .I_CPU_SLEEP(sleep), .O_IRQ(irq));

    capture_pin_model pin_src (.i_clock(clk), .o_pin(pin));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdata);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= wr; hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rdata = hrdata;
    endtask

    function automatic logic [15:0] ofs(input logic [2:0] m, input int k);
        case (m)
            3'h1: return 16'(k / 2);
            3'h4: return 16'(4 * k + 3);
            3'h5: return 16'(16 * k + 15);
            default: return 16'(k);
        endcase
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        row_t        r;
        logic [31:0] rd, ctrl;
        logic [15:0] base, v;
        rst = 1'b1; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
        idle = 1'b0; sleep = 1'b0; sec = 16'h0; hsize = 3'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `CAP_CTRL_OFS, 32'h0, rd); `CHK(rd, 32'h0)
        bus(1'b0, `CAP_IRQ_STAT_OFS, 32'h0, rd); `CHK(rd, 32'h0)
        bus(1'b1, `CAP_CTRL_OFS, 32'hffff_ffff, rd);
        bus(1'b0, `CAP_CTRL_OFS, 32'h0, rd); `CHK(rd, 32'h0000_20e7)
        bus(1'b0, 8'h20, 32'h0, rd); `CHK(rd, 32'h0)
        `CHK(hresp, 1'b0)
        for (int i = 0; i < 9; i++) begin
            r = rows[i];
            bus(1'b1, `CAP_CTRL_OFS, 32'h0, rd);
            bus(1'b1, `CAP_IRQ_CLR_OFS, 32'h7, rd);
            base = {i[3:0], 12'h5a0};
            sec <= base;
            bus(1'b1, `CAP_CTRL_OFS, {24'h0, r.tb, r.cpi, 2'b00, r.mode}, rd);
            for (int p = 0; p < r.n; p++) begin
                pin_src.pulses(1);
                repeat (6) @(posedge clk);
                sec <= sec + 16'h1;
            end
            ctrl = {24'h0, r.tb, r.cpi, r.stat[2], r.caps != 3'd0, r.mode};
            bus(1'b0, `CAP_CTRL_OFS, 32'h0, rd); `CHK(rd, ctrl)
            bus(1'b0, `CAP_IRQ_STAT_OFS, 32'h0, rd); `CHK(rd, {29'h0, r.stat})
            for (int k = 0; k < r.caps; k++) begin
                v = base + ofs(r.mode, k);
                bus(1'b0, `CAP_BUF_OFS, 32'h0, rd); `CHK(rd, {16'h0, r.tb ? v : ~v})
            end
            ctrl[3] = 1'b0;
            bus(1'b0, `CAP_CTRL_OFS, 32'h0, rd); `CHK(rd, ctrl)
        end
        // ----------------------------------------
        // Interrupt, idle and wake cases
        // ----------------------------------------
        bus(1'b1, `CAP_IRQ_EN_OFS, 32'h1, rd);
        bus(1'b1, `CAP_CTRL_OFS, 32'h3, rd);
        pin_src.pulses(1);
        repeat (8) @(posedge clk);
        `CHK(irq, 1'b1)
        bus(1'b1, `CAP_IRQ_EN_OFS, 32'h0, rd);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        bus(1'b1, `CAP_IRQ_EN_OFS, 32'h1, rd);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        bus(1'b1, `CAP_IRQ_CLR_OFS, 32'h1, rd);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        bus(1'b1, `CAP_IRQ_EN_OFS, 32'h0, rd);
        bus(1'b1, `CAP_CTRL_OFS, 32'h0, rd);
        bus(1'b1, `CAP_CTRL_OFS, 32'h2003, rd);
        idle <= 1'b1;
        pin_src.pulses(2);
        repeat (8) @(posedge clk);
        bus(1'b0, `CAP_CTRL_OFS, 32'h0, rd); `CHK(rd, 32'h0000_2003)
        bus(1'b1, `CAP_CTRL_OFS, 32'h0003, rd);
        pin_src.pulses(1);
        repeat (8) @(posedge clk);
        bus(1'b0, `CAP_CTRL_OFS, 32'h0, rd); `CHK(rd, 32'h0000_000b)
        idle <= 1'b0;
        bus(1'b1, `CAP_CTRL_OFS, 32'h0, rd);
        bus(1'b1, `CAP_IRQ_CLR_OFS, 32'h7, rd);
        bus(1'b1, `CAP_CTRL_OFS, 32'h7, rd);
        sleep <= 1'b1;
        pin_src.pulses(1);
        repeat (8) @(posedge clk);
        bus(1'b0, `CAP_IRQ_STAT_OFS, 32'h0, rd); `CHK(rd, 32'h2)
        bus(1'b0, `CAP_CTRL_OFS, 32'h0, rd); `CHK(rd, 32'h7)
        sleep <= 1'b0;
        close_out();
    end
endmodule

`default_nettype wire

// >>> src/capture_edge_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "capture_map.svh"

module capture_edge_prescaler (
    input  wire logic            i_clock,
    input  wire logic            i_rst,
    input  wire logic            i_pin,
    input  capture_pkg::mode_t   i_mode,
    input  wire logic            i_run,
    output logic                 o_capture,
    output logic                 o_rise
);
    import capture_pkg::*;

    edge_state_t s_r;
    edge_state_t s_nxt;
    logic        rise;
    logic        fall;

    // ----------------------------------------
    // Edge detection and prescaler
    // ----------------------------------------
    always_comb begin
        s_nxt         = s_r;
        s_nxt.sync1   = i_pin;
        s_nxt.sync2   = s_r.sync1;
        s_nxt.prev    = s_r.sync2;
        s_nxt.mode    = i_mode;
        s_nxt.capture = 1'b0;
        rise          = s_r.sync2 & ~s_r.prev;
        fall          = ~s_r.sync2 & s_r.prev;
        s_nxt.rise    = rise;
        // Fresh mode restarts the edge count
        if (i_mode != s_r.mode) begin
            s_nxt.presc = 4'h0;
        end else if (i_run) begin
            case (i_mode)
                MODE_ANY_EDGE: begin
                    s_nxt.capture = rise | fall;
                end
                MODE_FALL: begin
                    s_nxt.capture = fall;
                end
                MODE_RISE: begin
                    s_nxt.capture = rise;
                end
                MODE_RISE_4: begin
                    if (rise) begin
                        if (s_r.presc >= `CAP_PRESC_4_LAST) begin
                            s_nxt.presc   = 4'h0;
                            s_nxt.capture = 1'b1;
                        end else begin
                            s_nxt.presc = s_r.presc + 4'h1;
                        end
                    end
                end
                MODE_RISE_16: begin
                    if (rise) begin
                        if (s_r.presc == `CAP_PRESC_16_LAST) begin
                            s_nxt.presc   = 4'h0;
                            s_nxt.capture = 1'b1;
                        end else begin
                            s_nxt.presc = s_r.presc + 4'h1;
                        end
                    end
                end
                default: begin
                    // Off, unused and wake modes never capture
                    s_nxt.presc = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_capture = s_r.capture;
    assign o_rise    = s_r.rise;

endmodule

`default_nettype wire

// >>> src/capture_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "capture_map.svh"

module capture_fifo (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_flush,
    input  wire logic        i_push,
    input  wire logic [15:0] i_data,
    input  wire logic        i_pop,
    output logic      [15:0] o_head,
    output logic             o_full,
    output logic             o_empty
);
    import capture_pkg::*;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic        do_push;
    logic        do_pop;

    // ----------------------------------------
    // Four-entry capture store
    // ----------------------------------------
    always_comb begin
        s_nxt   = s_r;
        do_push = i_push & (s_r.count != `CAP_FIFO_DEPTH);
        do_pop  = i_pop & (s_r.count != 3'h0);
        if (i_flush) begin
            s_nxt.rd    = 2'h0;
            s_nxt.wr    = 2'h0;
            s_nxt.count = 3'h0;
        end else begin
            if (do_push) begin
                s_nxt.mem[s_r.wr] = i_data;
                s_nxt.wr          = s_r.wr + 2'h1;
            end
            if (do_pop) begin
                s_nxt.rd = s_r.rd + 2'h1;
            end
            if (do_push & ~do_pop) begin
                s_nxt.count = s_r.count + 3'h1;
            end else if (do_pop & ~do_push) begin
                s_nxt.count = s_r.count - 3'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_head  = s_r.mem[s_r.rd];
    assign o_full  = (s_r.count == `CAP_FIFO_DEPTH);
    assign o_empty = (s_r.count == 3'h0);

endmodule

`default_nettype wire

// >>> src/capture_map.svh
`ifndef CAPTURE_MAP_SVH
`define CAPTURE_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CAP_CTRL_OFS      8'h00
`define CAP_BUF_OFS       8'h04
`define CAP_IRQ_STAT_OFS  8'h08
`define CAP_IRQ_CLR_OFS   8'h0c
`define CAP_IRQ_EN_OFS    8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CAP_IDLE_STOP_BIT 13
`define CAP_TBSEL_BIT     7
`define CAP_CPI_MSB       6
`define CAP_CPI_LSB       5
`define CAP_OVF_BIT       4
`define CAP_BNE_BIT       3
`define CAP_MODE_MSB      2
`define CAP_MODE_LSB      0

// ----------------------------------------
// Interrupt status fields
// ----------------------------------------
`define CAP_IRQ_CAP_BIT   0
`define CAP_IRQ_WAKE_BIT  1
`define CAP_IRQ_OVF_BIT   2

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CAP_CTRL_RST      16'h0000
`define CAP_IRQ_RST       3'h0
`define CAP_FIFO_DEPTH    3'h4
`define CAP_PRESC_4_LAST  4'h3
`define CAP_PRESC_16_LAST 4'hf

`endif

// >>> src/capture_pkg.sv
package capture_pkg;

    typedef enum logic [2:0] {
        MODE_OFF       = 3'b000,
        MODE_ANY_EDGE  = 3'b001,
        MODE_FALL      = 3'b010,
        MODE_RISE      = 3'b011,
        MODE_RISE_4    = 3'b100,
        MODE_RISE_16   = 3'b101,
        MODE_UNUSED    = 3'b110,
        MODE_WAKE      = 3'b111
    } mode_t;

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        prev;
        mode_t       mode;
        logic [3:0]  presc;
        logic        capture;
        logic        rise;
    } edge_state_t;

    typedef struct packed {
        logic [3:0][15:0] mem;
        logic [1:0]       rd;
        logic [1:0]       wr;
        logic [2:0]       count;
    } fifo_state_t;

    typedef struct packed {
        logic        idle_stop;
        logic        tb_sel;
        logic [1:0]  cpi;
        mode_t       mode;
        logic        ovf;
        logic [1:0]  irq_cnt;
        logic [2:0]  irq_status;
        logic [2:0]  irq_enable;
        logic        irq;
        logic        dp_valid;
        logic        dp_write;
        logic [7:0]  dp_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
    } main_state_t;

endpackage

// >>> src/input_capture_channel.sv
// Overview of operation
// - Idle-stop bit halts channel during CPU idle
// - Time base select: one second, zero third
// - Interrupt after one to four captures
// - Read-only overflow flag set on overflow
// - Read-only flag shows buffer not empty
// - Status flags reset zero, hardware-cleared only
// - Mode 111: rising-edge wake interrupt only
// - Mode 110 behaves as disabled
// - Mode 101 captures every sixteenth rising edge
// - Mode 100 captures every fourth rising edge
// - Mode 011 rising, mode 010 falling edges
// - Mode 001 both edges, interrupt each capture
// - Mode 000 turns capture off
// - Unimplemented control bits read zero
// - Latch full sixteen-bit selected timer count
// - Captures held in four-entry buffer
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "capture_map.svh"

module input_capture_channel (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    input  wire logic        I_CAPTURE_INPUT_PIN,
    input  wire logic [15:0] I_SECOND_TIMER_COUNT,
    input  wire logic [15:0] I_THIRD_TIMER_COUNT,
    input  wire logic        I_CPU_IDLE,
    input  wire logic        I_CPU_SLEEP,
    output logic             O_IRQ
);
    import capture_pkg::*;

    main_state_t s_r;
    main_state_t s_nxt;

    logic        run;
    logic        cap_event;
    logic        rise_event;
    logic        fifo_push;
    logic        fifo_pop;
    logic        fifo_flush;
    logic [15:0] fifo_head;
    logic        fifo_full;
    logic        fifo_empty;
    logic [15:0] time_base;
    logic [2:0]  irq_set;
    logic [2:0]  irq_clr;
    logic        take;
    logic        disabled;

    // ----------------------------------------
    // Pin edges and prescaler
    // ----------------------------------------
    // Idle halt stops edge counting too, so no partial prescale is lost
    assign run = ~(s_r.idle_stop & I_CPU_IDLE);

    capture_edge_prescaler u_edge (
        .i_clock   (I_CLOCK),
        .i_rst     (I_RST),
        .i_pin     (I_CAPTURE_INPUT_PIN),
        .i_mode    (s_r.mode),
        .i_run     (run),
        .o_capture (cap_event),
        .o_rise    (rise_event)
    );

    // ----------------------------------------
    // Capture buffer
    // ----------------------------------------
    capture_fifo u_fifo (
        .i_clock (I_CLOCK),
        .i_rst   (I_RST),
        .i_flush (fifo_flush),
        .i_push  (fifo_push),
        .i_data  (time_base),
        .i_pop   (fifo_pop),
        .o_head  (fifo_head),
        .o_full  (fifo_full),
        .o_empty (fifo_empty)
    );

    // ----------------------------------------
    // Control word read-back
    // ----------------------------------------
    function automatic logic [15:0] ctrl_word(input main_state_t st, input logic bne);
        logic [15:0] w;
        w                                 = 16'h0000;
        w[`CAP_IDLE_STOP_BIT]             = st.idle_stop;
        w[`CAP_TBSEL_BIT]                 = st.tb_sel;
        w[`CAP_CPI_MSB:`CAP_CPI_LSB]      = st.cpi;
        w[`CAP_OVF_BIT]                   = st.ovf;
        w[`CAP_BNE_BIT]                   = bne;
        w[`CAP_MODE_MSB:`CAP_MODE_LSB]    = st.mode;
        return w;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        s_nxt      = s_r;
        irq_set    = 3'h0;
        irq_clr    = 3'h0;
        fifo_push  = 1'b0;
        fifo_pop   = 1'b0;
        fifo_flush = 1'b0;
        disabled   = 1'b0;
        time_base  = s_r.tb_sel ? I_SECOND_TIMER_COUNT : I_THIRD_TIMER_COUNT;
        take       = I_HSEL & I_HTRANS[1] & I_HREADY;

        // Data phase of a write
        if (s_r.dp_valid & s_r.dp_write) begin
            case (s_r.dp_addr)
                `CAP_CTRL_OFS: begin
                    // Flag bits are not writable
                    s_nxt.idle_stop = I_HWDATA[`CAP_IDLE_STOP_BIT];
                    s_nxt.tb_sel    = I_HWDATA[`CAP_TBSEL_BIT];
                    s_nxt.cpi       = I_HWDATA[`CAP_CPI_MSB:`CAP_CPI_LSB];
                    s_nxt.mode      = mode_t'(I_HWDATA[`CAP_MODE_MSB:`CAP_MODE_LSB]);
                end
                `CAP_IRQ_CLR_OFS: begin
                    irq_clr = I_HWDATA[2:0];
                end
                `CAP_IRQ_EN_OFS: begin
                    s_nxt.irq_enable = I_HWDATA[2:0];
                end
                default: begin
                end
            endcase
        end

        // Capture events
        if (cap_event) begin
            fifo_push = 1'b1;
            if (fifo_full) begin
                s_nxt.ovf                 = 1'b1;
                irq_set[`CAP_IRQ_OVF_BIT] = 1'b1;
            end
            if ((s_r.mode == MODE_ANY_EDGE) || (s_r.irq_cnt == s_r.cpi)) begin
                s_nxt.irq_cnt             = 2'h0;
                irq_set[`CAP_IRQ_CAP_BIT] = 1'b1;
            end else begin
                s_nxt.irq_cnt = s_r.irq_cnt + 2'h1;
            end
        end

        // Wake source mode ignores every other control setting
        if ((s_r.mode == MODE_WAKE) && rise_event && (I_CPU_IDLE | I_CPU_SLEEP)) begin
            irq_set[`CAP_IRQ_WAKE_BIT] = 1'b1;
        end

        // Off, unused or wake mode: hardware clears flags and empties buffer
        case (s_r.mode)
            MODE_OFF: begin
                disabled = 1'b1;
            end
            MODE_UNUSED: begin
                disabled = 1'b1;
            end
            MODE_WAKE: begin
                disabled = 1'b1;
            end
            default: begin
                disabled = 1'b0;
            end
        endcase
        if (disabled) begin
            s_nxt.ovf     = 1'b0;
            s_nxt.irq_cnt = 2'h0;
            fifo_flush    = 1'b1;
        end

        // Set wins over a clear in the same cycle
        s_nxt.irq_status = (s_r.irq_status & ~irq_clr) | irq_set;
        s_nxt.irq        = |(s_nxt.irq_status & s_nxt.irq_enable);

        // Address phase; read data prepared from next values
        s_nxt.dp_valid  = take;
        s_nxt.dp_write  = I_HWRITE;
        s_nxt.dp_addr   = I_HADDR[7:0];
        s_nxt.hreadyout = 1'b1;
        if (take & ~I_HWRITE) begin
            case (I_HADDR[7:0])
                `CAP_CTRL_OFS: begin
                    s_nxt.hrdata = {16'h0000, ctrl_word(s_nxt, ~fifo_empty)};
                end
                `CAP_BUF_OFS: begin
                    s_nxt.hrdata = {16'h0000, fifo_head};
                    fifo_pop     = ~fifo_flush;
                end
                `CAP_IRQ_STAT_OFS: begin
                    s_nxt.hrdata = {29'h0, s_nxt.irq_status};
                end
                `CAP_IRQ_EN_OFS: begin
                    s_nxt.hrdata = {29'h0, s_nxt.irq_enable};
                end
                default: begin
                    // Unmapped and write-only offsets read zero
                    s_nxt.hrdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            s_r           <= '0;
            s_r.hreadyout <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign O_HRDATA    = s_r.hrdata;
    assign O_HREADYOUT = s_r.hreadyout;
    assign O_HRESP     = 1'b0;
    assign O_IRQ       = s_r.irq;

endmodule

`default_nettype wire
